/* File: core/dcm_core.sv */
// DAC clock configuration, clock-present monitor, divided clock and data capture
// Behaviour
// - Sample-clock-present flag is set only while detector sees a clock; writes ignored.
// - Without sample clock, output is mid-scale and datapath is held in reset.
// - Bit 0 of the sample clock register powers down its receiver.
// - Sample clock and divided output register resets to zero.
// - Bit 5 selects divided output at quarter (0) or half (1) sample rate.
// - Bit 6 selects low (0) or high (1) divided output drive current.
// - Bit 7 enables internal termination on the divided output pair.
// - Bit 4 disables divided transmitter and floats both output pins.
// - Code words are captured on both edges of the data clock.
// - Bit 0 of the data clock register enables the data clock receiver.
// - Quadrature select is clear for in-phase clock, set for quadrature clock.
// - Delay trim sets in-phase clock delay; quadrature mode gives zero delay.
// - Without data clock the datapath is also held in reset.
// - Data clock register resets to zero: receiver off, in-phase, default trim.
`timescale 1ns/1ps
module dcm_core
  import dcm_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             spi_csn,
  input  wire logic             spi_sck,
  input  wire logic             spi_sdi,
  output logic                  spi_sdo,
  input  wire logic             sample_clock_det,
  input  wire logic             dataclk_det,
  input  wire logic             sample_tick,
  input  wire logic             data_clock_in,
  input  wire logic [DAC_W-1:0] dac_din,
  input  wire logic             pattern_gen_enable,
  input  wire logic [DAC_W-1:0] pattern_code,
  output logic [DAC_W-1:0]      dac_code,
  output logic                  datapath_rst,
  output logic                  sample_clock_rx_on,
  output logic                  dataclk_rx_on,
  output logic                  divclk_p,
  output logic                  divclk_n,
  output logic                  divclk_oe_n,
  output logic                  divclk_drive_hi,
  output logic                  divclk_term_on,
  output logic [9:0]            dataclk_delay_ps
);

  dcm_state_t s_reg;
  dcm_state_t s_next;

  // Signed trim steps around the nominal delay; unlisted codes follow the same step
  function automatic logic [9:0] trim_delay(input logic [2:0] trim, input logic quad);
    logic [9:0] step;
    step = DELAY_STEP_PS * {7'h00, trim[1:0]};
    if (quad)
      trim_delay = DELAY_ZERO_PS;
    else if (trim[2])
      trim_delay = DELAY_NOM_PS - (DELAY_STEP_PS * 10'h004) + step;
    else
      trim_delay = DELAY_NOM_PS + step;
  endfunction

  function automatic logic [7:0] read_reg(input logic [6:0] addr, input dcm_state_t st);
    read_reg = 8'h00;
    if (addr == ADDR_SCK_CTRL)
    begin
      read_reg[SCK_PD_BIT]    = st.ctrl.sck_pd;
      read_reg[SCK_OK_BIT]    = st.sck_ok;
      read_reg[DIV_DIS_BIT]   = st.ctrl.div_dis;
      read_reg[DIV_RATIO_BIT] = st.ctrl.div_ratio;
      read_reg[DIV_DRIVE_BIT] = st.ctrl.div_drive;
      read_reg[DIV_TERM_BIT]  = st.ctrl.div_term;
    end
    else if (addr == ADDR_DCK_CTRL)
    begin
      read_reg[DCK_EN_BIT]                   = st.ctrl.dck_en;
      read_reg[DCK_OK_BIT]                   = st.dck_ok;
      read_reg[DCK_Q_BIT]                    = st.ctrl.dck_q;
      read_reg[DCK_TRIM_LSB +: 3]            = st.ctrl.dck_trim;
    end
  endfunction

  always_comb
  begin
    logic       sck_rise;
    logic       sck_fall;
    logic [7:0] word;
    logic       dclk_edge;
    sck_rise  = spi_sck & ~s_reg.spi_sck_d;
    sck_fall  = ~spi_sck & s_reg.spi_sck_d;
    word      = {s_reg.spi_sh, spi_sdi};
    dclk_edge = data_clock_in ^ s_reg.dclk_d;
    s_next    = s_reg;

    // Detector outputs are asynchronous; second stage alone feeds the flags
    s_next.sck_det_s1 = sample_clock_det;
    s_next.sck_det_s2 = s_reg.sck_det_s1;
    s_next.dck_det_s1 = dataclk_det;
    s_next.dck_det_s2 = s_reg.dck_det_s1;
    // A powered-down receiver cannot report a clock
    s_next.sck_ok = s_reg.sck_det_s2 & ~s_reg.ctrl.sck_pd;
    s_next.dck_ok = s_reg.dck_det_s2 & s_reg.ctrl.dck_en;

    // SPI slave: pins are sampled, so sck must stay well below mclk/4
    s_next.spi_sck_d = spi_sck;
    if (spi_csn)
    begin
      s_next.spi_state = SPI_IDLE;
      s_next.spi_cnt   = 3'h0;
      s_next.spi_sdo   = 1'b0;
    end
    else
    begin
      unique case (s_reg.spi_state)
        SPI_IDLE:
        begin
          s_next.spi_state = SPI_CMD;
          s_next.spi_cnt   = 3'h0;
        end
        SPI_CMD:
        begin
          if (sck_rise)
          begin
            s_next.spi_sh  = word[6:0];
            s_next.spi_cnt = s_reg.spi_cnt + 3'h1;
            if (s_reg.spi_cnt == SPI_LAST_BIT)
            begin
              s_next.spi_rd    = word[7];
              s_next.spi_addr  = word[6:0];
              s_next.spi_rdata = read_reg(word[6:0], s_reg);
              s_next.spi_state = SPI_DATA;
            end
          end
        end
        SPI_DATA:
        begin
          if (sck_fall && s_reg.spi_rd)
          begin
            s_next.spi_sdo   = s_reg.spi_rdata[7];
            s_next.spi_rdata = {s_reg.spi_rdata[6:0], 1'b0};
          end
          if (sck_rise)
          begin
            s_next.spi_sh  = word[6:0];
            s_next.spi_cnt = s_reg.spi_cnt + 3'h1;
            if (s_reg.spi_cnt == SPI_LAST_BIT)
            begin
              s_next.spi_state = SPI_DONE;
              if (!s_reg.spi_rd && s_reg.spi_addr == ADDR_SCK_CTRL)
              begin
                // Present flag bit is read-only and not stored
                s_next.ctrl.sck_pd    = word[SCK_PD_BIT];
                s_next.ctrl.div_dis   = word[DIV_DIS_BIT];
                s_next.ctrl.div_ratio = word[DIV_RATIO_BIT];
                s_next.ctrl.div_drive = word[DIV_DRIVE_BIT];
                s_next.ctrl.div_term  = word[DIV_TERM_BIT];
              end
              else if (!s_reg.spi_rd && s_reg.spi_addr == ADDR_DCK_CTRL)
              begin
                s_next.ctrl.dck_en   = word[DCK_EN_BIT];
                s_next.ctrl.dck_q    = word[DCK_Q_BIT];
                s_next.ctrl.dck_trim = word[DCK_TRIM_LSB +: 3];
              end
            end
          end
        end
        SPI_DONE:
        begin
          if (sck_fall)
            s_next.spi_sdo = 1'b0;
        end
      endcase
    end

    // Double data rate capture: every level change of the data clock takes a word unless the datapath is in reset
    s_next.dclk_d = data_clock_in;
    s_next.dp_rst = ~s_reg.sck_ok | ~s_reg.dck_ok;
    if (s_reg.dp_rst)
      s_next.captured = DAC_MID_SCALE;
    else if (dclk_edge)
      s_next.captured = dac_din;

    if (!s_reg.sck_ok)
      s_next.dac_code = DAC_MID_SCALE;
    else if (pattern_gen_enable)
      s_next.dac_code = pattern_code;
    else if (!s_reg.dck_ok)
      s_next.dac_code = DAC_MID_SCALE;
    else
      s_next.dac_code = s_reg.captured;

    // Divided clock: half rate toggles each sample tick, quarter every second
    if (s_reg.ctrl.div_dis || !s_reg.sck_ok)
    begin
      s_next.div_cnt   = 1'b0;
      s_next.div_phase = 1'b0;
    end
    else if (sample_tick)
    begin
      s_next.div_cnt = ~s_reg.div_cnt;
      if (s_reg.ctrl.div_ratio || s_reg.div_cnt)
        s_next.div_phase = ~s_reg.div_phase;
    end
    s_next.div_oe_n     = s_reg.ctrl.div_dis;
    s_next.div_p        = ~s_reg.ctrl.div_dis & s_next.div_phase;
    s_next.div_n        = ~s_reg.ctrl.div_dis & ~s_next.div_phase;
    s_next.div_drive_hi = s_reg.ctrl.div_drive;
    s_next.div_term_on  = s_reg.ctrl.div_term;

    s_next.sck_rx_on = ~s_reg.ctrl.sck_pd;
    s_next.dck_rx_on = s_reg.ctrl.dck_en;
    s_next.delay_ps  = trim_delay(s_reg.ctrl.dck_trim, s_reg.ctrl.dck_q);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s_reg              <= '0;
      s_reg.ctrl         <= dcm_ctrl_t'({SCK_CTRL_RST[7:4], SCK_CTRL_RST[0],
                                         DCK_CTRL_RST[6:4], DCK_CTRL_RST[2],
                                         DCK_CTRL_RST[0]});
      s_reg.spi_state    <= SPI_IDLE;
      s_reg.sck_rx_on    <= 1'b1;
      s_reg.div_n        <= 1'b1;
      s_reg.delay_ps     <= DELAY_NOM_PS;
    end
    else
      s_reg <= s_next;
  end

  assign spi_sdo            = s_reg.spi_sdo;
  assign dac_code           = s_reg.dac_code;
  assign datapath_rst       = s_reg.dp_rst;
  assign sample_clock_rx_on = s_reg.sck_rx_on;
  assign dataclk_rx_on      = s_reg.dck_rx_on;
  assign divclk_p           = s_reg.div_p;
  assign divclk_n           = s_reg.div_n;
  assign divclk_oe_n        = s_reg.div_oe_n;
  assign divclk_drive_hi    = s_reg.div_drive_hi;
  assign divclk_term_on     = s_reg.div_term_on;
  assign dataclk_delay_ps   = s_reg.delay_ps;

  // Ticks never come on adjacent cycles; the pair below expects one every fourth mclk
  sequence quarter_tick;
    sample_tick && !s_reg.ctrl.div_ratio && !s_reg.ctrl.div_dis && s_reg.sck_ok;
  endsequence

  // Of two successive quarter-rate ticks exactly one toggles the pins
  sequence quarter_tick_pair;
    quarter_tick ##4 quarter_tick;
  endsequence

  a_sck_flag_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(s_reg.sck_det_s2) && !s_reg.ctrl.sck_pd && !$past(s_reg.ctrl.sck_pd)
    |=> s_reg.sck_ok) else $error("sample clock flag did not follow detector");
  a_sck_flag_drop: assert property (@(posedge mclk) disable iff (!rst_n)
    !s_reg.sck_det_s2 |=> !s_reg.sck_ok)
    else $error("sample clock flag stayed set without detector");
  a_mute_no_sck: assert property (@(posedge mclk) disable iff (!rst_n)
    !s_reg.sck_ok |=> dac_code == DAC_MID_SCALE && datapath_rst)
    else $error("output not muted without sample clock");
  a_rx_powerdown: assert property (@(posedge mclk) disable iff (!rst_n)
    s_reg.ctrl.sck_pd |=> !sample_clock_rx_on && !s_reg.sck_ok)
    else $error("sample clock receiver not powered down");
  a_ctrl_reset: assert property (@(posedge mclk)
    !rst_n |=> s_reg.ctrl == '0 && sample_clock_rx_on && !divclk_oe_n)
    else $error("control registers not cleared by reset");
  a_half_rate: assert property (@(posedge mclk) disable iff (!rst_n)
    sample_tick && s_reg.ctrl.div_ratio && !s_reg.ctrl.div_dis && s_reg.sck_ok
    |=> divclk_p != $past(divclk_p)) else $error("half rate output missed a toggle");
  a_quarter_rate: assert property (@(posedge mclk) disable iff (!rst_n)
    quarter_tick_pair |=> divclk_p != $past(divclk_p, 5))
    else $error("quarter rate output wrong");
  a_drive_term: assert property (@(posedge mclk) disable iff (!rst_n)
    ##1 divclk_drive_hi == $past(s_reg.ctrl.div_drive)
    && divclk_term_on == $past(s_reg.ctrl.div_term))
    else $error("divided output drive or termination wrong");
  a_div_float: assert property (@(posedge mclk) disable iff (!rst_n)
    s_reg.ctrl.div_dis |=> divclk_oe_n && !divclk_p && !divclk_n)
    else $error("disabled divided output still driven");
  a_ddr_capture: assert property (@(posedge mclk) disable iff (!rst_n)
    (data_clock_in != s_reg.dclk_d) && !s_reg.dp_rst |=> s_reg.captured == $past(dac_din))
    else $error("data word not captured on clock edge");
  a_mute_no_dck: assert property (@(posedge mclk) disable iff (!rst_n)
    !s_reg.dck_ok && !pattern_gen_enable |=> dac_code == DAC_MID_SCALE && datapath_rst)
    else $error("output not muted without data clock");
  a_quad_delay: assert property (@(posedge mclk) disable iff (!rst_n)
    s_reg.ctrl.dck_q |=> dataclk_delay_ps == DELAY_ZERO_PS)
    else $error("quadrature mode delay not zero");
  a_inphase_delay: assert property (@(posedge mclk) disable iff (!rst_n)
    !s_reg.ctrl.dck_q && s_reg.ctrl.dck_trim == 3'b110 |=> dataclk_delay_ps == 10'h0E6)
    else $error("in-phase delay trim wrong");
  a_pattern_override: assert property (@(posedge mclk) disable iff (!rst_n)
    s_reg.sck_ok && pattern_gen_enable |=> dac_code == $past(pattern_code))
    else $error("pattern word did not override the output");
  a_div_pair: assert property (@(posedge mclk) disable iff (!rst_n)
    !divclk_oe_n |-> divclk_n == !divclk_p)
    else $error("driven divided output pair not complementary");
  a_dck_rx_gate: assert property (@(posedge mclk) disable iff (!rst_n)
    !s_reg.ctrl.dck_en |=> !dataclk_rx_on && !s_reg.dck_ok)
    else $error("data clock receiver active while disabled");
  a_dck_rx_on: assert property (@(posedge mclk) disable iff (!rst_n)
    s_reg.ctrl.dck_en |=> dataclk_rx_on)
    else $error("data clock receiver not enabled");

endmodule

/* File: core/dcm_pkg.sv */
// Shared constants and types for the DAC clock configuration and monitor block
package dcm_pkg;

  localparam int DAC_W = 16;
  localparam logic [DAC_W-1:0] DAC_MID_SCALE = 16'h0000;

  localparam logic [6:0] ADDR_SCK_CTRL = 7'h02;
  localparam logic [6:0] ADDR_DCK_CTRL = 7'h03;
  localparam logic [7:0] SCK_CTRL_RST  = 8'h00;
  localparam logic [7:0] DCK_CTRL_RST  = 8'h00;

  localparam int SCK_PD_BIT    = 0;
  localparam int SCK_OK_BIT    = 1;
  localparam int DIV_DIS_BIT   = 4;
  localparam int DIV_RATIO_BIT = 5;
  localparam int DIV_DRIVE_BIT = 6;
  localparam int DIV_TERM_BIT  = 7;
  localparam int DCK_EN_BIT    = 0;
  localparam int DCK_OK_BIT    = 1;
  localparam int DCK_Q_BIT     = 2;
  localparam int DCK_TRIM_LSB  = 4;

  // Detector thresholds, kept for reference; the analog detectors apply them
  localparam int SCK_MIN_MHZ = 50;
  localparam int DCK_MIN_MHZ = 25;

  localparam logic [9:0] DELAY_NOM_PS  = 10'h190;
  localparam logic [9:0] DELAY_STEP_PS = 10'h055;
  localparam logic [9:0] DELAY_ZERO_PS = 10'h000;

  localparam logic [2:0] SPI_LAST_BIT = 3'h7;

  typedef enum logic [3:0]
  {
    SPI_IDLE = 4'b0001,
    SPI_CMD  = 4'b0010,
    SPI_DATA = 4'b0100,
    SPI_DONE = 4'b1000
  } dcm_spi_state_t;

  typedef struct packed
  {
    logic       div_term;
    logic       div_drive;
    logic       div_ratio;
    logic       div_dis;
    logic       sck_pd;
    logic [2:0] dck_trim;
    logic       dck_q;
    logic       dck_en;
  } dcm_ctrl_t;

  typedef struct packed
  {
    dcm_ctrl_t        ctrl;
    logic             sck_det_s1;
    logic             sck_det_s2;
    logic             dck_det_s1;
    logic             dck_det_s2;
    logic             sck_ok;
    logic             dck_ok;
    dcm_spi_state_t   spi_state;
    logic             spi_sck_d;
    logic [2:0]       spi_cnt;
    logic [6:0]       spi_sh;
    logic             spi_rd;
    logic [6:0]       spi_addr;
    logic [7:0]       spi_rdata;
    logic             spi_sdo;
    logic             dclk_d;
    logic [DAC_W-1:0] captured;
    logic [DAC_W-1:0] dac_code;
    logic             dp_rst;
    logic             div_cnt;
    logic             div_phase;
    logic             div_p;
    logic             div_n;
    logic             div_oe_n;
    logic             div_drive_hi;
    logic             div_term_on;
    logic             sck_rx_on;
    logic             dck_rx_on;
    logic [9:0]       delay_ps;
  } dcm_state_t;

endpackage

/* File: tb/dcm_host_model.sv */
// Host side model: drives the DDR data clock and code words into the block
`timescale 1ns/1ps
module dcm_host_model
  import dcm_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             run,
  input  wire logic             dual,
  output logic                  data_clock_in,
  output logic [DAC_W-1:0]      dac_din
);
  int cnt = 0;

  initial data_clock_in = 1'b0;
  initial dac_din = 16'h0000;

  // Sample period is four mclk, so a half period of 4 or 8 gives fDAC/2 or fDAC/4
  always @(negedge mclk)
  begin
    if (!run)
    begin
      // Clock stands still between bursts; idle data must not look stable
      cnt <= 0;
      dac_din <= ~dac_din;
    end
    else if (cnt == (dual ? 7 : 3))
    begin
      cnt <= 0;
      dac_din <= 16'($urandom);
      data_clock_in <= ~data_clock_in;
    end
    else
      cnt <= cnt + 1;
  end
endmodule

/* File: tb/testbench.sv */
// Self-checking testbench for the DAC clock configuration and monitor block
`timescale 1ns/1ps
module testbench
  import dcm_pkg::*;
;
  logic             mclk;
  logic             rst_n = 1'b0;
  logic             spi_csn = 1'b1;
  logic             spi_sck = 1'b0;
  logic             spi_sdi = 1'b0;
  logic             sample_clock_det = 1'b0;
  logic             dataclk_det = 1'b0;
  logic             sample_tick = 1'b0;
  logic             pattern_gen_enable = 1'b0;
  logic [DAC_W-1:0] pattern_code = 16'h0000;
  logic             run = 1'b0;
  logic             dual = 1'b0;
  logic             cap_on = 1'b0;
  logic             spi_sdo, datapath_rst, sample_clock_rx_on, dataclk_rx_on;
  logic             divclk_p, divclk_n, divclk_oe_n, divclk_drive_hi, divclk_term_on;
  logic             data_clock_in;
  logic [DAC_W-1:0] dac_code, dac_din;
  logic [9:0]       dataclk_delay_ps;
  logic [7:0]       rd_byte, junk;
  logic [2:0]       tr;
  logic [16:0]      exp_q[$];
  logic [16:0]      e;
  event             res_ev;
  int               error_cnt = 0;
  int               n_checks = 0;
  int               tick_cnt = 0;
  int               n;

  dcm_core dut (.mclk, .rst_n, .spi_csn, .spi_sck, .spi_sdi, .spi_sdo, .sample_clock_det,
    .dataclk_det, .sample_tick, .data_clock_in, .dac_din, .pattern_gen_enable,
    .pattern_code, .dac_code, .datapath_rst, .sample_clock_rx_on, .dataclk_rx_on,
    .divclk_p, .divclk_n, .divclk_oe_n, .divclk_drive_hi, .divclk_term_on, .dataclk_delay_ps);

  dcm_host_model host (.mclk, .run, .dual, .data_clock_in, .dac_din);

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(negedge mclk)
  begin
    tick_cnt <= (tick_cnt + 1) % 4;
    sample_tick <= (tick_cnt == 3);
  end

  task check(input logic [15:0] seen, input logic [15:0] expv);
    n_checks++;
    if (seen !== expv)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, expv);
    end
  endtask

  task end_sim;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Slow SCK (low 4, high 2 mclk) leaves margin for the design's edge detection
  task spi(input logic [15:0] w, output logic [7:0] r);
    spi_csn = 1'b0;
    repeat (2) @(negedge mclk);
    for (int i = 15; i >= 0; i--)
    begin
      spi_sdi = w[i];
      spi_sck = 1'b0;
      repeat (4) @(negedge mclk);
      if (i < 8)
        r[i] = spi_sdo;
      spi_sck = 1'b1;
      repeat (2) @(negedge mclk);
    end
    spi_sck = 1'b0;
    repeat (2) @(negedge mclk);
    spi_csn = 1'b1;
    repeat (4) @(negedge mclk);
  endtask

  task wr(input logic [6:0] a, input logic [7:0] d);
    spi({1'b0, a, d}, junk);
  endtask

  task rd(input logic [6:0] a, input logic [7:0] x);
    spi({1'b1, a, 8'h00}, rd_byte);
    exp_q.push_back({1'b0, 8'h00, x});
    ->res_ev;
  endtask

  task count_rises(output int cnt);
    logic prev;
    cnt = 0;
    prev = divclk_p;
    repeat (128)
    begin
      @(negedge mclk);
      cnt = cnt + int'(divclk_p && !prev);
      prev = divclk_p;
    end
  endtask

  initial
  forever
  begin
    @(res_ev);
    e = exp_q.pop_front();
    check(e[16] ? dac_code : {8'h00, rd_byte}, e[15:0]);
  end

  // Each data clock change carries a word; it must reach the output either edge
  initial
  forever
  begin
    @(data_clock_in);
    #1;
    if (cap_on)
    begin
      exp_q.push_back({1'b1, dac_din});
      repeat (3) @(negedge mclk);
      ->res_ev;
    end
  end

  initial
  begin
    #200us;
    error_cnt++;
    end_sim;
  end

  initial
  begin
    void'($urandom(29701));
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    check(16'(sample_clock_rx_on), 16'h0001);
    check(16'({divclk_oe_n, divclk_drive_hi, divclk_term_on}), 16'h0000);
    check(16'(dataclk_rx_on), 16'h0000);
    check(16'(dataclk_delay_ps), 16'h0190);
    rd(ADDR_SCK_CTRL, SCK_CTRL_RST);
    rd(ADDR_DCK_CTRL, DCK_CTRL_RST);
    wr(ADDR_SCK_CTRL, 8'hFF);
    rd(ADDR_SCK_CTRL, 8'hF1);
    check(16'(sample_clock_rx_on), 16'h0000);
    check(16'({divclk_oe_n, divclk_p, divclk_n}), 16'h0004);
    check(16'(divclk_drive_hi), 16'h0001);
    check(16'(divclk_term_on), 16'h0001);
    wr(7'h05, 8'hA5);
    rd(7'h05, 8'h00);
    wr(ADDR_SCK_CTRL, 8'h00);
    sample_clock_det = 1'b1;
    repeat (6) @(negedge mclk);
    rd(ADDR_SCK_CTRL, 8'h02);
    check(16'(datapath_rst), 16'h0001);
    check(dac_code, DAC_MID_SCALE);
    for (int r = 0; r < 2; r++)
    begin
      wr(ADDR_SCK_CTRL, 8'(r << DIV_RATIO_BIT));
      count_rises(n);
      check(16'(n), 16'(8 << r));
    end
    for (int t = 0; t < 9; t++)
    begin
      tr = (t < 8) ? 3'(t) : 3'($urandom);
      wr(ADDR_DCK_CTRL, {1'b0, tr, 1'b0, (t == 8), 2'b01});
      check(16'(dataclk_delay_ps), (t < 8) ? 16'(16'sh0190 + 16'sh0055 * $signed(tr)) : 16'h0000);
    end
    check(16'(dataclk_rx_on), 16'h0001);
    wr(ADDR_DCK_CTRL, 8'h01);
    dataclk_det = 1'b1;
    repeat (6) @(negedge mclk);
    rd(ADDR_DCK_CTRL, 8'h03);
    check(16'(datapath_rst), 16'h0000);
    run = 1'b1;
    cap_on = 1'b1;
    repeat (80) @(negedge mclk);
    dual = 1'b1;
    repeat (160) @(negedge mclk);
    cap_on = 1'b0;
    repeat (4) @(negedge mclk);
    sample_clock_det = 1'b0;
    repeat (8) @(negedge mclk);
    check(dac_code, DAC_MID_SCALE);
    check(16'(datapath_rst), 16'h0001);
    sample_clock_det = 1'b1;
    dataclk_det = 1'b0;
    pattern_code = 16'($urandom);
    pattern_gen_enable = 1'b1;
    repeat (8) @(negedge mclk);
    check(dac_code, pattern_code);
    pattern_gen_enable = 1'b0;
    repeat (8) @(negedge mclk);
    check(dac_code, DAC_MID_SCALE);
    check(16'(datapath_rst), 16'h0001);
    end_sim;
  end
endmodule
